// File: coherent_load_pkg.sv
`default_nettype none

package coherent_load_pkg;

   // Clock relation between the bus clock and the counter clock
   typedef enum logic [1:0] {
      CLK_IDENTICAL   = 2'b00,
      CLK_SYNCHRONOUS = 2'b01,
      CLK_ASYNC       = 2'b10
   } clock_mode_type;

   // Documented widths
   localparam int LOAD_REG_WIDTH = 32;
   localparam int BUS_DATA_WIDTH = 8;
   localparam int BYTE_BITS      = 8;

   // Reset values
   localparam logic [31:0] LOAD_VALUE_RESET = 32'h00000000;
   localparam logic        FLAG_RESET       = 1'b0;

endpackage

`default_nettype wire

// File: periph_clk_retimer.sv
`timescale 1ns/1ps
`default_nettype none

module periph_clk_retimer (
   input  wire logic clk,        // Bus clock
   input  wire logic rst,        // Async reset, active high
   input  wire logic ce,         // Clock enable
   input  wire logic periph_clk, // Counter clock level, sampled
   output logic      periph_rise // One-cycle pulse per counter clock rise
);
   import coherent_load_pkg::*;

   typedef struct packed {
      logic meta;
      logic stable;
      logic delayed;
      logic rise;
   } retime_state_type;

   retime_state_type s;
   retime_state_type next_s;

   // Two-flop synchroniser, then a third stage for edge detection
   always_comb begin
      next_s         = s;
      next_s.meta    = periph_clk;
      next_s.stable  = s.meta;
      next_s.delayed = s.stable;
      next_s.rise    = s.stable & ~s.delayed; // First flop never feeds this gate
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign periph_rise = s.rise;

endmodule

`default_nettype wire

// File: coherent_load_register_writer.sv
// Functional notes
// - Final byte index from register and bus width
// - No shadow when one access covers register
// - Lower bytes shadowed; load value held meanwhile
// - Upper write moves shadow and byte together
// - Counter keeps old value during partial write
// - Identical clocks: one-cycle load strobe
// - Periodic counter reloads from load value
// - Synchronous clocks: strobe held until counter edge
// - Toggle flips on counter edge with strobe
// - Toggle edge clears strobe as counter loads
// - Async: retime counter clock, capture on edge
// - Counter edge copies load value to safe copy
// - Pending flag copied safe; loads on edge
// - Toggle per final write; edge clears both flags
// - Async value arrives within two counter periods
`timescale 1ns/1ps
`default_nettype none

module coherent_load_register_writer #(
   parameter int REG_WIDTH = coherent_load_pkg::LOAD_REG_WIDTH,
   parameter int BUS_WIDTH = coherent_load_pkg::BUS_DATA_WIDTH
) (
   input  wire logic                            clk,             // Bus clock, 10 MHz
   input  wire logic                            rst,             // Async reset, active high
   input  wire logic                            ce,              // Clock enable, freezes all
   input  wire coherent_load_pkg::clock_mode_type clock_mode,    // Clock relation
   input  wire logic                            wr_en,           // Bus write strobe
   input  wire logic [1:0]                      wr_addr,         // Byte address of the access
   input  wire logic [BUS_WIDTH-1:0]            wr_data,         // Bus write data
   input  wire logic                            periph_clk,      // Counter clock, sampled
   output logic [REG_WIDTH-1:0]                 load_value_reg,  // Coherent load value
   output logic [REG_WIDTH-1:0]                 synced_load_value_reg, // Async safe copy
   output logic                                 counter_load_strobe,   // Extended load strobe
   output logic                                 pending_load_flag,     // New value waiting
   output logic                                 synced_pending_flag,   // Safe copy of it
   output logic                                 counter_load_qual,     // Counter loads now
   output logic                                 write_toggle,          // Flips per new value
   output logic                                 load_toggle            // Counter-side toggle
);
   import coherent_load_pkg::*;

   localparam int  BUS_BYTES  = BUS_WIDTH / BYTE_BITS;
   localparam bit  NO_COHERENCY_NEEDED = (REG_WIDTH <= BUS_WIDTH);
   localparam int  UPPER_BYTE = ((REG_WIDTH - 1) / BUS_WIDTH) * BUS_BYTES;
   localparam int  PAD_WIDTH  = 32 + BUS_WIDTH;

   typedef struct packed {
      logic [REG_WIDTH-1:0] shadow;
      logic [REG_WIDTH-1:0] load_value;
      logic [REG_WIDTH-1:0] synced_value;
      logic                 strobe;
      logic                 pending;
      logic                 synced_pending;
      logic                 qual;
      logic                 wr_toggle;
      logic                 ld_toggle;
      logic                 ld_toggle_seen;
   } writer_state_type;

   writer_state_type s;
   writer_state_type next_s;
   logic             periph_rise;
   logic             final_wr;
   logic             ack_edge;
   logic [PAD_WIDTH-1:0] merged;

   // Counter clock seen from the bus clock; no multi-bit word crosses raw
   periph_clk_retimer u_retimer (
      .clk         (clk),
      .rst         (rst),
      .ce          (ce),
      .periph_clk  (periph_clk),
      .periph_rise (periph_rise)
   );

   // Upper byte ends the write; single-access widths need no shadow
   assign final_wr = wr_en && (NO_COHERENCY_NEEDED ||
                     (wr_addr == UPPER_BYTE[1:0]));
   assign ack_edge = s.ld_toggle ^ s.ld_toggle_seen;

   // Shadow bytes overlaid with the byte lane being written
   always_comb begin
      merged = PAD_WIDTH'(s.shadow);
      if (NO_COHERENCY_NEEDED) begin
         merged = PAD_WIDTH'(wr_data);
      end else begin
         merged[{wr_addr, 3'b000} +: BUS_WIDTH] = wr_data;
      end
   end

   // Next-state logic for the whole writer
   always_comb begin
      next_s                = s;
      next_s.qual           = 1'b0;
      next_s.ld_toggle_seen = s.ld_toggle;
      if (wr_en && !final_wr && !NO_COHERENCY_NEEDED) begin
         next_s.shadow = merged[REG_WIDTH-1:0];
      end
      // Load value only moves on the final byte, so reloads use the old one
      if (final_wr) begin
         next_s.load_value = merged[REG_WIDTH-1:0];
         next_s.wr_toggle  = ~s.wr_toggle;
      end
      unique case (clock_mode)
         CLK_IDENTICAL: begin
            next_s.strobe = final_wr;
            next_s.qual   = final_wr;
         end
         CLK_SYNCHRONOUS: begin
            if (periph_rise && s.strobe) begin
               next_s.ld_toggle = ~s.ld_toggle;
               next_s.qual      = 1'b1;
            end
            // Clear by toggle edge; a new final write wins over it
            if (ack_edge) begin
               next_s.strobe = 1'b0;
            end
            if (final_wr) begin
               next_s.strobe = 1'b1;
            end
         end
         CLK_ASYNC: begin
            if (periph_rise) begin
               next_s.synced_value   = s.load_value;
               next_s.synced_pending = s.pending;
               if (s.synced_pending) begin
                  next_s.ld_toggle = ~s.ld_toggle;
                  next_s.qual      = 1'b1;
               end
            end
            if (ack_edge) begin
               next_s.pending        = 1'b0;
               next_s.synced_pending = 1'b0;
            end
            if (final_wr) begin
               next_s.pending = 1'b1;
            end
         end
         default: begin
            next_s.strobe = 1'b0;  // Unused code: hold off any load
         end
      endcase
   end

   // Reset leaves nothing that could trigger a counter load
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s                <= '0;
         s.load_value     <= REG_WIDTH'(LOAD_VALUE_RESET);
         s.synced_value   <= REG_WIDTH'(LOAD_VALUE_RESET);
         s.strobe         <= FLAG_RESET;
         s.pending        <= FLAG_RESET;
         s.synced_pending <= FLAG_RESET;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign load_value_reg        = s.load_value;
   assign synced_load_value_reg = s.synced_value;
   assign counter_load_strobe   = s.strobe;
   assign pending_load_flag     = s.pending;
   assign synced_pending_flag   = s.synced_pending;
   assign counter_load_qual     = s.qual;
   assign write_toggle          = s.wr_toggle;
   assign load_toggle           = s.ld_toggle;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst || !ce);

   property p_hold_partial;
      wr_en && !final_wr ##1 ce |-> $stable(load_value_reg);
   endproperty
   a_hold_partial: assert property (p_hold_partial)
      else $error("load value changed on a non-final byte");

   // A final write one cycle later legally keeps the strobe up for another cycle
   property p_ident_pulse;
      clock_mode == CLK_IDENTICAL && final_wr |=>
         counter_load_strobe && counter_load_qual ##1
         ($past(final_wr) || !counter_load_strobe);
   endproperty
   a_ident_pulse: assert property (p_ident_pulse)
      else $error("identical mode strobe not one cycle");

   property p_sync_hold;
      clock_mode == CLK_SYNCHRONOUS && counter_load_strobe && !periph_rise && !ack_edge
         |=> counter_load_strobe;
   endproperty
   a_sync_hold: assert property (p_sync_hold)
      else $error("strobe dropped before counter edge");

   property p_toggle_flip;
      clock_mode == CLK_SYNCHRONOUS && periph_rise && counter_load_strobe
         |=> load_toggle != $past(load_toggle) ##1 ($past(final_wr) || !counter_load_strobe);
   endproperty
   a_toggle_flip: assert property (p_toggle_flip)
      else $error("toggle did not flip or strobe not cleared");

   property p_toggle_keep;
      !periph_rise |=> $stable(load_toggle);
   endproperty
   a_toggle_keep: assert property (p_toggle_keep)
      else $error("toggle moved without a counter edge");

   property p_safe_copy;
      clock_mode == CLK_ASYNC && periph_rise |=>
         synced_load_value_reg == $past(load_value_reg) &&
         synced_pending_flag == $past(pending_load_flag);
   endproperty
   a_safe_copy: assert property (p_safe_copy)
      else $error("safe copy not taken on counter edge");

   property p_safe_stable;
      clock_mode == CLK_ASYNC && !periph_rise |=> $stable(synced_load_value_reg);
   endproperty
   a_safe_stable: assert property (p_safe_stable)
      else $error("safe value changed off a counter edge");

   property p_flag_clear;
      clock_mode == CLK_ASYNC && ack_edge && !final_wr |=>
         !pending_load_flag && !synced_pending_flag;
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("toggle edge did not clear pending flags");

   property p_final_toggle;
      final_wr |=> write_toggle != $past(write_toggle);
   endproperty
   a_final_toggle: assert property (p_final_toggle)
      else $error("write toggle not flipped on new value");

   generate
      if (!NO_COHERENCY_NEEDED) begin : g_shadow_check
         property p_merge;
            final_wr |=> load_value_reg[UPPER_BYTE*BYTE_BITS-1:0] ==
               $past(s.shadow[UPPER_BYTE*BYTE_BITS-1:0]);
         endproperty
         a_merge: assert property (p_merge)
            else $error("shadow bytes not merged on final write");
      end
   endgenerate

endmodule

`default_nettype wire

// File: counter_side_model.sv
`timescale 1ns/1ps
`default_nettype none

module counter_side_model (
   input  wire logic                              clk,        // Bus clock
   input  wire logic                              rst,        // Async reset, active high
   input  wire coherent_load_pkg::clock_mode_type clock_mode, // Clock relation
   input  wire logic                              load_qual,  // Counter loads now
   input  wire logic [31:0]                       load_value, // Coherent load value
   input  wire logic [31:0]                       safe_value, // Async safe copy
   output logic                                   periph_clk, // Counter clock
   output logic                                   loaded,     // Pulse after each load_qual load, not after a reload at zero
   output logic [31:0]                            count       // Counter contents
);
   import coherent_load_pkg::*;
   logic [1:0] div;
   logic       async_clk;
   logic       tick_d;
   logic [31:0] reload;

   // Free-running async clock, 730 ns, odd offset so phase never lines up
   initial begin
      async_clk = 1'b0;
      #37;
      forever #365 async_clk = ~async_clk;
   end

   assign periph_clk = (clock_mode == CLK_ASYNC) ? async_clk : div[1];

   // Only the async counter may read the safe copy; others use the load value
   assign reload = (clock_mode == CLK_ASYNC) ? safe_value : load_value;

   // Divide-by-four clock for the synchronous case; counter on the bus clock
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         div <= 2'h0;
         tick_d <= 1'b0;
         loaded <= 1'b0;
         count <= 32'h0;
      end else begin
         div <= div + 2'h1;
         tick_d <= periph_clk;
         loaded <= load_qual;
         if (load_qual) begin
            count <= reload;
         end else if (periph_clk && !tick_d) begin
            count <= (count == 32'h0) ? reload : count - 32'h1;
         end
      end
   end
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import coherent_load_pkg::*;
   logic           clk;
   logic           rst;
   logic           ce;
   clock_mode_type clock_mode;
   logic           wr_en;
   logic [1:0]     wr_addr;
   logic [7:0]     wr_data;
   wire logic      periph_clk;
   wire logic [31:0] lv;
   wire logic [31:0] slv;
   wire logic      strobe;
   wire logic      pend;
   wire logic      spend;
   wire logic      qual;
   wire logic      wtog;
   wire logic      ltog;
   wire logic      loaded;
   wire logic [31:0] count;
   integer         errors;
   integer         tests_run;
   integer         seed;
   logic [31:0]    exp_q[$];

   coherent_load_register_writer DUT (.clk(clk), .rst(rst), .ce(ce), .clock_mode(clock_mode),
      .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .periph_clk(periph_clk),
      .load_value_reg(lv), .synced_load_value_reg(slv), .counter_load_strobe(strobe),
      .pending_load_flag(pend), .synced_pending_flag(spend), .counter_load_qual(qual),
      .write_toggle(wtog), .load_toggle(ltog));
   counter_side_model partner (.clk(clk), .rst(rst), .clock_mode(clock_mode),
      .load_qual(qual), .load_value(lv), .safe_value(slv), .periph_clk(periph_clk),
      .loaded(loaded), .count(count));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         errors = errors + 1;
         $display("ERROR %0t %s: saw %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic check1(input logic seen, input logic exp, input string what);
      check({31'h0, seen}, {31'h0, exp}, what);
   endtask

   task automatic stop_test;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Bytes go out low to high; only a run that reaches byte 3 commits
   task automatic write_bytes(input logic [31:0] v, input int last);
      logic [31:0] old;
      logic        tog;
      old = lv;
      tog = wtog;
      if (last == 3) exp_q.push_back(v);
      for (int i = 0; i <= last; i++) begin
         wr_en = 1'b1;
         wr_addr = i[1:0];
         wr_data = v[8*i +: 8];
         @(posedge clk);
         #5;
         if (i < 3) check(lv, old, "value moved early");
      end
      wr_en = 1'b0;
      if (last == 3) check(lv, v, "merged value");
      if (last == 3) check1(wtog, ~tog, "write toggle");
   endtask

   // Follows the handover to the counter for the current clock relation
   task automatic follow_load(input logic [31:0] v);
      logic tog;
      int   k;
      tog = ltog;
      k = 0;
      if (clock_mode == CLK_IDENTICAL) begin
         check1(strobe & qual, 1'b1, "strobe pulse");
         @(posedge clk);
         #5;
         check1(strobe, 1'b0, "strobe one cycle");
      end else begin
         if (clock_mode == CLK_ASYNC) check1(pend, 1'b1, "pending set");
         while (qual !== 1'b1 && k < 20) begin
            if (clock_mode == CLK_SYNCHRONOUS) check1(strobe, 1'b1, "strobe held");
            @(posedge clk);
            #5;
            k++;
         end
         check1(qual, 1'b1, "load late");
         check1(ltog, ~tog, "load toggle");
         if (clock_mode == CLK_ASYNC) check(slv, v, "safe value");
         if (clock_mode == CLK_ASYNC) check1(spend, 1'b1, "safe pending");
         @(posedge clk);
         #5;
         check1(strobe | pend | spend, 1'b0, "flags not cleared");
      end
   endtask

   // Scoreboard: every load_qual counter load takes the oldest committed value
   always @(posedge clk) begin
      if (loaded === 1'b1) begin
         if (exp_q.size() == 0) check1(1'b1, 1'b0, "unexpected load");
         else check(count, exp_q.pop_front(), "loaded value");
      end
   end

   initial begin
      #200000;
      errors = errors + 1;
      $display("ERROR %0t watchdog expired", $time);
      stop_test();
   end

   initial begin
      logic [31:0] v;
      seed = 56358;
      errors = 0;
      tests_run = 0;
      rst = 1'b1;
      ce = 1'b1;
      clock_mode = CLK_IDENTICAL;
      wr_en = 1'b0;
      wr_addr = 2'h0;
      wr_data = 8'h00;
      repeat (6) @(posedge clk);
      #5;
      check(lv | slv, 32'h0, "reset value");
      rst = 1'b0;
      @(posedge clk);
      #5;
      check1(strobe | pend | spend | qual | wtog | ltog, 1'b0, "flags after reset");
      for (int m = 0; m < 3; m++) begin
         clock_mode = clock_mode_type'(m[1:0]);
         repeat (2) @(posedge clk);
         #5;
         // Abandoned partial word must not commit or load
         write_bytes($random(seed), 2);
         repeat (25) @(posedge clk);
         #5;
         for (int n = 0; n < 3; n++) begin
            v = $random(seed);
            write_bytes(v, 3);
            follow_load(v);
            repeat (3) @(posedge clk);
            #5;
         end
      end
      check(exp_q.size(), 32'h0, "loads missing");
      stop_test();
   end
endmodule
`default_nettype wire
